// >>> shared/lrsa_defines.svh
`ifndef LRSA_DEFINES_SVH
`define LRSA_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LRSA_ADDR_SEC 16'h0200
`define LRSA_ADDR_MIN 16'h0201
`define LRSA_ADDR_HR 16'h0202
`define LRSA_ADDR_DAY 16'h0203
`define LRSA_ADDR_MON 16'h0204
`define LRSA_ADDR_YR 16'h0205
`define LRSA_ADDR_INT_LO 16'h0206
`define LRSA_ADDR_INT_HI 16'h0207
`define LRSA_ADDR_THR_LO 16'h0208
`define LRSA_ADDR_THR_HI 16'h0209
`define LRSA_ADDR_RES_LO 16'h020C
`define LRSA_ADDR_RES_HI 16'h020D
`define LRSA_ADDR_ALM_CTRL 16'h0210
`define LRSA_ADDR_RTC_CTRL 16'h0212
`define LRSA_ADDR_ALM_STAT 16'h0214

// ----------------------------------------
// Writable bit masks (fixed-zero cells cleared)
// ----------------------------------------
`define LRSA_MASK_SEC 8'h7F
`define LRSA_MASK_HR 8'h7F
`define LRSA_MASK_DAY 8'h3F
`define LRSA_MASK_MON 8'h9F
`define LRSA_MASK_INT_HI 8'h3F
`define LRSA_MASK_CTRL 8'h03

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LRSA_HR_MODE12 6
`define LRSA_HR_PM20 5
`define LRSA_HR_TEN 4
`define LRSA_MON_CENTURY_TOGGLE 7
`define LRSA_CTRL_B0 0
`define LRSA_CTRL_B1 1
`define LRSA_ALM_STAT_FIXED 8'h70

// ----------------------------------------
// Reset values, result codes and minute prescale limit
// ----------------------------------------
`define LRSA_RST_ZERO 8'h00
`define LRSA_RST_ONE 8'h01
`define LRSA_RES_OVER_HI 8'hFF
`define LRSA_RES_OVER_LO16 8'hE0
`define LRSA_SEC_PER_MIN 6'h3B

// ----------------------------------------
// Timing
// ----------------------------------------
`define LRSA_CLK_PERIOD_NS 10
`define LRSA_TICK_PERIOD_NS 1000000000
`define LRSA_TICK_CYCLES (`LRSA_TICK_PERIOD_NS / `LRSA_CLK_PERIOD_NS)

`endif

// >>> shared/lrsa_pkg.sv
package lrsa_pkg;

  // Full state of the clock, calendar and measurement registers
  typedef struct packed {
    logic [26:0] div;
    logic tick;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic [7:0] day;
    logic [7:0] mon;
    logic [7:0] yr;
    logic [7:0] int_lo;
    logic [7:0] int_hi;
    logic [7:0] thr_lo;
    logic [7:0] thr_hi;
    logic [7:0] res_lo;
    logic [7:0] res_hi;
    logic [1:0] alm_ctrl;
    logic [1:0] rtc_ctrl;
    logic flag_lo;
    logic flag_hi;
    logic [7:0] rdata;
  } lrsa_state_s;

  // Sample timer state
  typedef struct packed {
    logic [5:0] presc;
    logic [13:0] cnt;
    logic req;
  } lrsa_timer_s;

endpackage : lrsa_pkg

// >>> shared/lrsa_timer_if.sv
`timescale 1ns/1ps

interface lrsa_timer_if;
  logic tick_1s;
  logic run;
  logic unit_sec;
  logic [13:0] interval;
  logic conv_req;

  modport ctrl (output tick_1s, output run, output unit_sec, output interval, input conv_req);
  modport timer (input tick_1s, input run, input unit_sec, input interval, output conv_req);
endinterface : lrsa_timer_if

// >>> core/lrsa_sample_timer.sv
`timescale 1ns/1ps
`include "lrsa_defines.svh"

module lrsa_sample_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Link to the clock block
  lrsa_timer_if.timer tif
);

  lrsa_pkg::lrsa_timer_s t_reg;
  lrsa_pkg::lrsa_timer_s t_next;
  logic [13:0] cnt_inc;

  // Unit prescale, interval count and conversion request
  always_comb begin
    t_next = t_reg;
    t_next.req = 1'b0;
    cnt_inc = 14'(t_reg.cnt + 14'h0001);
    if (!tif.run) begin
      t_next.presc = '0;
      t_next.cnt = '0;
    end else if (tif.tick_1s) begin
      // Minutes are built from seconds so both units share one timebase
      if (tif.unit_sec || t_reg.presc == `LRSA_SEC_PER_MIN) begin
        t_next.presc = '0;
        // A zero interval matches only when the 14-bit count wraps, after 16384 units
        if (cnt_inc == tif.interval) begin
          t_next.cnt = '0;
          t_next.req = 1'b1;
        end else begin
          t_next.cnt = cnt_inc;
        end
      end else begin
        t_next.presc = 6'(t_reg.presc + 6'h01);
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      t_reg <= '0;
    end else begin
      t_reg <= t_next;
    end
  end

  assign tif.conv_req = t_reg.req;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_req_on_tick: assert property (@(posedge clk) disable iff (!arst_n)
    tif.conv_req |-> $past(tif.tick_1s) && $past(tif.run))
    else $error("conversion request without a counted unit");

endmodule : lrsa_sample_timer

// >>> core/lrsa_top.sv
// Function
// - Clock and calendar values held as BCD
// - Fixed-zero clock bits always read zero
// - Hours bit 6 selects 12-hour mode
// - Hours bit 5 is PM or twenties
// - Century bit writable, toggles on year wrap
// - Leap February when year divisible by four
// - Interval is 14-bit, top bits zero
// - Interval counted in seconds or minutes
// - Interval registers locked during a mission
// - High result valid, low five bits zero
// - Low result undefined in 8-bit mode
// - Out-of-range results give fixed codes
// - Results unsigned, half or sixteenth degree
// - Alarms compare only the high byte
// - Low alarm flag when enabled and at or below
// - High alarm flag when enabled and at or above
// - Alarm flags visible in alarm status
// - Alarm control locked, bits 2-7 zero
// - Unit select at clock control bit 1
// - Format select: 0 8-bit, 1 16-bit
`timescale 1ns/1ps
`include "lrsa_defines.svh"

module lrsa_top #(
  parameter int TICK_CYCLES = `LRSA_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Mission control
  input wire logic mission_active,
  input wire logic log_format_select,
  input wire logic alarm_flag_clear,
  // Conversion
  output logic conv_req,
  input wire logic conv_done,
  input wire logic conv_under,
  input wire logic conv_over,
  input wire logic [10:0] conv_code,
  // Status
  output logic oscillator_enable,
  output logic low_alarm_flag,
  output logic high_alarm_flag
);

  lrsa_pkg::lrsa_state_s s_reg;
  lrsa_pkg::lrsa_state_s s_next;
  lrsa_timer_if tif ();

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Next BCD value, units roll into tens
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      return {v[7:4], 4'(v[3:0] + 4'h1)};
    end
  endfunction : bcd_inc

  // Year 00 counts as leap; no century exception
  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      return y[3:0] == 4'h2 || y[3:0] == 4'h6;
    end else begin
      return y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8;
    end
  endfunction : is_leap

  // Last day of the month in BCD
  function automatic logic [7:0] last_day(input logic [4:0] m, input logic [7:0] y);
    case (m)
      5'h02: last_day = is_leap(y) ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction : last_day

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  logic c_min;
  logic c_hr;
  logic c_day;
  logic c_mon;
  logic c_yr;
  logic lock;
  logic [7:0] nres_hi;
  logic [7:0] nres_lo;
  logic [7:0] mtmp;

  // Timebase, calendar, register writes, results, alarms and reads
  always_comb begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    c_min = 1'b0;
    c_hr = 1'b0;
    c_day = 1'b0;
    c_mon = 1'b0;
    c_yr = 1'b0;
    mtmp = 8'h00;
    nres_hi = s_reg.res_hi;
    nres_lo = s_reg.res_lo;
    lock = mission_active;

    // 1 Hz enable; the divider is cleared while the oscillator is stopped
    if (!s_reg.rtc_ctrl[`LRSA_CTRL_B0]) begin
      s_next.div = '0;
    end else if (s_reg.div == 27'(TICK_CYCLES - 1)) begin
      s_next.div = '0;
      s_next.tick = 1'b1;
    end else begin
      s_next.div = 27'(s_reg.div + 27'h1);
    end

    // Calendar carry chain, all digits kept in BCD
    if (s_reg.tick) begin
      c_min = s_reg.sec[6:0] == 7'h59;
      s_next.sec = c_min ? 8'h00 : bcd_inc(s_reg.sec);
    end
    if (c_min) begin
      c_hr = s_reg.min[6:0] == 7'h59;
      s_next.min = c_hr ? 8'h00 : bcd_inc(s_reg.min);
    end
    if (c_hr) begin
      if (s_reg.hr[`LRSA_HR_MODE12]) begin
        // 11 -> 12 flips AM/PM; the day ends at 11 PM -> 12 AM
        if (s_reg.hr[4:0] == 5'h12) begin
          s_next.hr[4:0] = 5'h01;
        end else if (s_reg.hr[4:0] == 5'h11) begin
          s_next.hr[4:0] = 5'h12;
          s_next.hr[`LRSA_HR_PM20] = ~s_reg.hr[`LRSA_HR_PM20];
          c_day = s_reg.hr[`LRSA_HR_PM20];
        end else begin
          mtmp = bcd_inc({3'b000, s_reg.hr[4:0]});
          s_next.hr[4:0] = mtmp[4:0];
        end
      end else begin
        // Bit 5 is the twenties digit in 24-hour mode
        if (s_reg.hr[5:0] == 6'h23) begin
          s_next.hr[5:0] = 6'h00;
          c_day = 1'b1;
        end else if (s_reg.hr[3:0] == 4'h9) begin
          s_next.hr[5:0] = s_reg.hr[`LRSA_HR_TEN] ? 6'h20 : 6'h10;
        end else begin
          s_next.hr[3:0] = 4'(s_reg.hr[3:0] + 4'h1);
        end
      end
    end
    if (c_day) begin
      c_mon = s_reg.day == last_day(s_reg.mon[4:0], s_reg.yr);
      s_next.day = c_mon ? `LRSA_RST_ONE : bcd_inc(s_reg.day);
    end
    if (c_mon) begin
      c_yr = s_reg.mon[4:0] == 5'h12;
      mtmp = bcd_inc({3'b000, s_reg.mon[4:0]});
      s_next.mon[4:0] = c_yr ? 5'h01 : mtmp[4:0];
    end
    if (c_yr) begin
      if (s_reg.yr == 8'h99) begin
        s_next.yr = 8'h00;
        s_next.mon[`LRSA_MON_CENTURY_TOGGLE] = ~s_reg.mon[`LRSA_MON_CENTURY_TOGGLE];
      end else begin
        s_next.yr = bcd_inc(s_reg.yr);
      end
    end

    // Host writes land after the tick so the written value wins
    if (reg_wr) begin
      case (reg_addr)
        `LRSA_ADDR_SEC: s_next.sec = reg_wdata & `LRSA_MASK_SEC;
        `LRSA_ADDR_MIN: s_next.min = reg_wdata & `LRSA_MASK_SEC;
        `LRSA_ADDR_HR: s_next.hr = reg_wdata & `LRSA_MASK_HR;
        `LRSA_ADDR_DAY: s_next.day = reg_wdata & `LRSA_MASK_DAY;
        `LRSA_ADDR_MON: s_next.mon = reg_wdata & `LRSA_MASK_MON;
        `LRSA_ADDR_YR: s_next.yr = reg_wdata;
        `LRSA_ADDR_INT_LO: if (!lock) s_next.int_lo = reg_wdata;
        `LRSA_ADDR_INT_HI: if (!lock) s_next.int_hi = reg_wdata & `LRSA_MASK_INT_HI;
        `LRSA_ADDR_THR_LO: if (!lock) s_next.thr_lo = reg_wdata;
        `LRSA_ADDR_THR_HI: if (!lock) s_next.thr_hi = reg_wdata;
        `LRSA_ADDR_ALM_CTRL: if (!lock) s_next.alm_ctrl = reg_wdata[1:0];
        `LRSA_ADDR_RTC_CTRL: if (!lock) s_next.rtc_ctrl = reg_wdata[1:0];
        default: ;
      endcase
    end

    // Result capture; the low byte only carries meaning in 16-bit mode
    if (conv_done) begin
      if (conv_under) begin
        nres_hi = 8'h00;
        nres_lo = 8'h00;
      end else if (conv_over) begin
        nres_hi = `LRSA_RES_OVER_HI;
        nres_lo = log_format_select ? `LRSA_RES_OVER_LO16 : 8'h00;
      end else begin
        nres_hi = conv_code[10:3];
        // 8-bit mode leaves the low byte undefined; zero is cheapest
        nres_lo = log_format_select ? {conv_code[2:0], 5'b00000} : 8'h00;
      end
      s_next.res_hi = nres_hi;
      s_next.res_lo = nres_lo;
    end

    // Alarm flags: a new alarm wins over a clear in the same cycle
    if (alarm_flag_clear) begin
      s_next.flag_lo = 1'b0;
      s_next.flag_hi = 1'b0;
    end
    if (conv_done && mission_active) begin
      if (s_reg.alm_ctrl[`LRSA_CTRL_B0] && nres_hi <= s_reg.thr_lo) begin
        s_next.flag_lo = 1'b1;
      end
      if (s_reg.alm_ctrl[`LRSA_CTRL_B1] && nres_hi >= s_reg.thr_hi) begin
        s_next.flag_hi = 1'b1;
      end
    end

    // Read data is held until the next read; unmapped offsets read zero
    if (reg_rd) begin
      case (reg_addr)
        `LRSA_ADDR_SEC: s_next.rdata = s_reg.sec;
        `LRSA_ADDR_MIN: s_next.rdata = s_reg.min;
        `LRSA_ADDR_HR: s_next.rdata = s_reg.hr;
        `LRSA_ADDR_DAY: s_next.rdata = s_reg.day;
        `LRSA_ADDR_MON: s_next.rdata = s_reg.mon;
        `LRSA_ADDR_YR: s_next.rdata = s_reg.yr;
        `LRSA_ADDR_INT_LO: s_next.rdata = s_reg.int_lo;
        `LRSA_ADDR_INT_HI: s_next.rdata = s_reg.int_hi;
        `LRSA_ADDR_THR_LO: s_next.rdata = s_reg.thr_lo;
        `LRSA_ADDR_THR_HI: s_next.rdata = s_reg.thr_hi;
        `LRSA_ADDR_RES_LO: s_next.rdata = s_reg.res_lo;
        `LRSA_ADDR_RES_HI: s_next.rdata = s_reg.res_hi;
        `LRSA_ADDR_ALM_CTRL: s_next.rdata = {6'b000000, s_reg.alm_ctrl};
        `LRSA_ADDR_RTC_CTRL: s_next.rdata = {6'b000000, s_reg.rtc_ctrl};
        `LRSA_ADDR_ALM_STAT: begin
          s_next.rdata = `LRSA_ALM_STAT_FIXED | {6'b000000, s_reg.flag_hi, s_reg.flag_lo};
        end
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Calendar starts at 00:00:00, day 01, month 01, year 00
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_reg <= '0;
      s_reg.day <= `LRSA_RST_ONE;
      s_reg.mon <= `LRSA_RST_ONE;
      s_reg.int_lo <= `LRSA_RST_ONE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Sample timer
  // ----------------------------------------
  // Runs only in a mission with the oscillator going
  assign tif.tick_1s = s_reg.tick;
  assign tif.run = mission_active && s_reg.rtc_ctrl[`LRSA_CTRL_B0];
  assign tif.unit_sec = s_reg.rtc_ctrl[`LRSA_CTRL_B1];
  assign tif.interval = {s_reg.int_hi[5:0], s_reg.int_lo};

  lrsa_sample_timer u_timer (
    .clk(clk),
    .arst_n(arst_n),
    .tif(tif)
  );

  // Outputs
  assign conv_req = tif.conv_req;
  assign reg_rdata = s_reg.rdata;
  assign oscillator_enable = s_reg.rtc_ctrl[`LRSA_CTRL_B0];
  assign low_alarm_flag = s_reg.flag_lo;
  assign high_alarm_flag = s_reg.flag_hi;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_conv_in_mission;
    conv_done && mission_active && !conv_under && !conv_over;
  endsequence

  a_bcd_seconds: assert property (
    !reg_wr && s_reg.sec[3:0] <= 4'h9 && s_reg.sec[6:4] <= 3'h5 |=> s_reg.sec[3:0] <= 4'h9)
    else $error("seconds left BCD range");

  a_fixed_zero: assert property (
    !s_reg.sec[7] && !s_reg.min[7] && !s_reg.hr[7] && s_reg.day[7:6] == 2'b00)
    else $error("fixed-zero clock bit set");

  a_century_flip: assert property (
    s_reg.tick && s_reg.yr == 8'h99 && s_reg.mon[4:0] == 5'h12 && s_reg.day == 8'h31
    && s_reg.hr == 8'h23 && s_reg.min == 8'h59 && s_reg.sec == 8'h59 && !reg_wr
    |=> s_reg.yr == 8'h00 && s_reg.mon[7] != $past(s_reg.mon[7]))
    else $error("century bit did not toggle on year wrap");

  a_leap_feb: assert property (
    s_reg.tick && s_reg.mon[4:0] == 5'h02 && s_reg.day == 8'h28 && s_reg.hr == 8'h23
    && s_reg.min == 8'h59 && s_reg.sec == 8'h59 && !reg_wr
    |=> s_reg.day == (is_leap(s_reg.yr) ? 8'h29 : 8'h01))
    else $error("wrong day after 28 February");

  a_interval_lock: assert property (
    mission_active && reg_wr && (reg_addr == `LRSA_ADDR_INT_LO || reg_addr == `LRSA_ADDR_INT_HI)
    |=> {s_reg.int_hi, s_reg.int_lo} == $past({s_reg.int_hi, s_reg.int_lo}))
    else $error("interval written during a mission");

  a_result_over: assert property (
    conv_done && conv_over && !conv_under && log_format_select
    |=> s_reg.res_hi == 8'hFF && s_reg.res_lo == 8'hE0)
    else $error("over-range code wrong");

  a_result_low5: assert property (
    s_reg.res_lo[4:0] == 5'b00000 && s_reg.int_hi[7:6] == 2'b00)
    else $error("low result or interval high fixed bits set");

  a_low_alarm: assert property (
    s_conv_in_mission ##0 (s_reg.alm_ctrl[0] && conv_code[10:3] <= s_reg.thr_lo)
    |=> s_reg.flag_lo ##1 (s_reg.flag_lo || $past(alarm_flag_clear)))
    else $error("low alarm flag not set");

  a_high_cause: assert property (
    $rose(s_reg.flag_hi) |-> $past(conv_done && mission_active && s_reg.alm_ctrl[1]))
    else $error("high alarm flag set without enabled cause");

  a_ctrl_zero: assert property (
    reg_rd && reg_addr == `LRSA_ADDR_ALM_CTRL |=> reg_rdata[7:2] == 6'b000000)
    else $error("alarm control upper bits read nonzero");

endmodule : lrsa_top

// >>> testbench/lrsa_host_model.sv
`timescale 1ns/1ps

module lrsa_host_model (
  // Clock
  input wire logic clk,
  // Register port toward the block
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // One write; released lines are scrambled so stale values cannot pass
  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
    @(posedge clk);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~addr;
    reg_wdata <= ~data;
  endtask : wr

  // One read; data is taken 1 ns after the edge that samples the strobe
  task automatic rd(input logic [15:0] addr, output logic [7:0] data);
    @(posedge clk);
    reg_addr <= addr;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~addr;
    #1;
    data = reg_rdata;
  endtask : rd

  // Clock set as {sec,min,hr,day,mon,yr}, seconds first
  task automatic wr_clock(input logic [47:0] t);
    for (int i = 0; i < 6; i++) begin
      wr(16'h0200 + 16'(i), t[47-8*i -: 8]);
    end
  endtask : wr_clock

  // Time is only consistent as one burst from seconds upward
  task automatic rd_clock(output logic [47:0] t);
    logic [7:0] b;
    for (int i = 0; i < 6; i++) begin
      rd(16'h0200 + 16'(i), b);
      t[47-8*i -: 8] = b;
    end
  endtask : rd_clock

  // A zero interval stretches the gap to 16384 units, so it is never sent
  task automatic set_interval(input logic [13:0] v);
    if (v != 14'h0000) begin
      wr(16'h0207, {2'b00, v[13:8]});
      wr(16'h0206, v[7:0]);
    end
  endtask : set_interval

  // Thresholds go as single bytes in the half-degree result code
  task automatic set_thresholds(input logic [7:0] lo, input logic [7:0] hi);
    wr(16'h0208, lo);
    wr(16'h0209, hi);
  endtask : set_thresholds
endmodule : lrsa_host_model

// >>> testbench/lrsa_top_bench.sv
`timescale 1ns/1ps

module lrsa_top_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int TICK = 10;
  logic clk, arst_n, reg_wr, reg_rd, mission_active, log_format_select, alarm_flag_clear;
  logic conv_req, conv_done, conv_under, conv_over, oscillator_enable;
  logic low_alarm_flag, high_alarm_flag;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [10:0] conv_code;
  logic [47:0] t;
  logic [15:0] w;
  int error_cnt = 0;
  int checked = 0;
  int n;

  // ----------------------------------------
  // Block, host and clock
  // ----------------------------------------
  lrsa_top #(.TICK_CYCLES(TICK)) dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mission_active(mission_active), .log_format_select(log_format_select),
    .alarm_flag_clear(alarm_flag_clear), .conv_req(conv_req), .conv_done(conv_done),
    .conv_under(conv_under), .conv_over(conv_over), .conv_code(conv_code),
    .oscillator_enable(oscillator_enable), .low_alarm_flag(low_alarm_flag),
    .high_alarm_flag(high_alarm_flag));
  lrsa_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // One conversion result; the code is scrambled once the strobe drops
  task automatic conv(input logic u, input logic o, input logic [10:0] code);
    @(posedge clk);
    conv_done <= 1'b1;
    conv_under <= u;
    conv_over <= o;
    conv_code <= code;
    @(posedge clk);
    conv_done <= 1'b0;
    conv_code <= ~code;
    @(posedge clk);
    #1;
  endtask : conv

  task automatic rd16(input logic [15:0] a, output logic [15:0] r);
    logic [7:0] b;
    host.rd(a + 16'h0001, b);
    r[15:8] = b;
    host.rd(a, b);
    r[7:0] = b;
  endtask : rd16

  task automatic clear_flags();
    @(posedge clk);
    alarm_flag_clear <= 1'b1;
    @(posedge clk);
    alarm_flag_clear <= 1'b0;
  endtask : clear_flags

  // Cycles between two conversion requests, bounded both ways
  task automatic req_gap(output int g);
    int k;
    k = 0;
    while (conv_req !== 1'b1 && k < 2000) begin
      @(posedge clk);
      #1;
      k++;
    end
    g = 0;
    do begin
      @(posedge clk);
      #1;
      g++;
    end while (conv_req !== 1'b1 && g < 2000);
  endtask : req_gap

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("idle outputs", {conv_req, low_alarm_flag, high_alarm_flag, oscillator_enable}, 0);
    host.rd_clock(t);
    chk("reset clock", t, 48'h0000_0001_0100);
    rd16(16'h0206, w);
    chk("reset interval", w, 16'h0001);
  endtask : t_reset

  // Every written cell of a fixed-zero bit must still read zero
  task automatic t_fixed_zero();
    logic [15:0] a [8] = '{16'h0200, 16'h0201, 16'h0202, 16'h0203, 16'h0204, 16'h0207,
      16'h0210, 16'h0212};
    logic [7:0] e [8] = '{8'h7F, 8'h7F, 8'h7F, 8'h3F, 8'h9F, 8'h3F, 8'h03, 8'h03};
    for (int i = 0; i < 8; i++) begin
      host.wr(a[i], 8'hFF);
      host.rd(a[i], v);
      chk("masked write", v, e[i]);
      host.wr(a[i], 8'h00);
    end
    host.rd(16'h0211, v);
    chk("unmapped read", v, 8'h00);
  endtask : t_fixed_zero

  // Each case sits one second before a carry; the clock runs until it moves
  task automatic t_calendar();
    logic [47:0] ci [6] = '{48'h5959_2331_1299, 48'h5959_2328_0200, 48'h5959_2328_0201,
      48'h5959_5115_0610, 48'h5959_1930_0410, 48'h5959_7130_0410};
    logic [47:0] co [6] = '{48'h0000_0001_8100, 48'h0000_0029_0200, 48'h0000_0001_0301,
      48'h0000_7215_0610, 48'h0000_2030_0410, 48'h0000_5201_0510};
    for (int i = 0; i < 6; i++) begin
      host.wr_clock(ci[i]);
      host.wr(16'h0212, 8'h01);
      v = 8'h59;
      for (int k = 0; k < 40 && v === 8'h59; k++) host.rd(16'h0200, v);
      host.wr(16'h0212, 8'h00);
      host.rd_clock(t);
      chk("calendar carry", t, co[i]);
    end
  endtask : t_calendar

  // Result bytes for each format and each range case
  task automatic t_results();
    logic [13:0] c [7] = '{{3'b100, 11'h2A0}, {3'b100, 11'h0BB}, {3'b000, 11'h0BB},
      {3'b111, 11'h0BB}, {3'b010, 11'h0BB}, {3'b101, 11'h0BB}, {3'b001, 11'h0BB}};
    logic [15:0] e [7] = '{16'h5400, 16'h1760, 16'h1700, 16'h0000, 16'h0000, 16'hFFE0,
      16'hFF00};
    for (int i = 0; i < 7; i++) begin
      log_format_select <= c[i][13];
      conv(c[i][12], c[i][11], c[i][10:0]);
      rd16(16'h020C, w);
      chk("result bytes", w, e[i]);
    end
  endtask : t_results

  task automatic t_alarms();
    host.set_thresholds(8'h60, 8'h80);
    host.wr(16'h0210, 8'h03);
    conv(1'b0, 1'b0, 11'h280);
    chk("flags off mission", {low_alarm_flag, high_alarm_flag}, 2'b00);
    mission_active <= 1'b1;
    conv(1'b0, 1'b0, {8'h60, 3'h7});
    host.rd(16'h0214, v);
    chk("low alarm status", v, 8'h71);
    clear_flags();
    conv(1'b0, 1'b0, {8'h80, 3'h0});
    host.rd(16'h0214, v);
    chk("high alarm status", v, 8'h72);
    clear_flags();
    conv(1'b0, 1'b0, {8'h61, 3'h0});
    chk("flags in band", {low_alarm_flag, high_alarm_flag}, 2'b00);
    mission_active <= 1'b0;
    host.wr(16'h0210, 8'h00);
    mission_active <= 1'b1;
    conv(1'b0, 1'b0, 11'h080);
    conv(1'b0, 1'b0, 11'h780);
    chk("flags disabled", {low_alarm_flag, high_alarm_flag}, 2'b00);
    mission_active <= 1'b0;
  endtask : t_alarms

  task automatic t_timer();
    host.set_interval(14'h0002);
    host.wr(16'h0212, 8'h03);
    mission_active <= 1'b1;
    host.wr(16'h0206, 8'h55);
    host.wr(16'h0210, 8'h03);
    host.rd(16'h0206, v);
    chk("interval locked", v, 8'h02);
    host.rd(16'h0210, v);
    chk("alarm ctrl locked", v, 8'h00);
    req_gap(n);
    chk("second unit gap", n, 2 * TICK);
    mission_active <= 1'b0;
    host.set_interval(14'h0001);
    // Output is looked at after the edge that loads it has settled
    host.wr(16'h0212, 8'h00);
    #1;
    chk("oscillator off", oscillator_enable, 1'b0);
    host.wr(16'h0212, 8'h01);
    #1;
    chk("oscillator bit", oscillator_enable, 1'b1);
    mission_active <= 1'b1;
    req_gap(n);
    chk("minute unit gap", n, 60 * TICK);
    mission_active <= 1'b0;
  endtask : t_timer

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    arst_n = 1'b0;
    mission_active = 1'b0;
    log_format_select = 1'b0;
    alarm_flag_clear = 1'b0;
    conv_done = 1'b0;
    conv_under = 1'b0;
    conv_over = 1'b0;
    conv_code = 11'h000;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_fixed_zero();
    t_calendar();
    t_results();
    t_alarms();
    t_timer();
    summarize();
  end

  // Whole run needs a few thousand cycles; this limit is far beyond that
  initial begin
    #400000;
    error_cnt++;
    summarize();
  end
endmodule : lrsa_top_bench
